// File: common/snv_pkg.sv
package snv_pkg;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;

  // Shadowed regions, backed by the nonvolatile store (octal 700-777, 7400-7577, 36000-37777)
  localparam logic [ADDR_W-1:0] SHADOW_A_LO = 14'h01C0;
  localparam logic [ADDR_W-1:0] SHADOW_A_HI = 14'h01FF;
  localparam logic [ADDR_W-1:0] SHADOW_B_LO = 14'h0F00;
  localparam logic [ADDR_W-1:0] SHADOW_B_HI = 14'h0F7F;
  localparam logic [ADDR_W-1:0] SHADOW_C_LO = 14'h3C00;
  localparam logic [ADDR_W-1:0] SHADOW_C_HI = 14'h3FFF;

  // RAM-only regions (octal 400-677, 1200-7377, 10000-17777)
  localparam logic [ADDR_W-1:0] RAMONLY_A_LO = 14'h0100;
  localparam logic [ADDR_W-1:0] RAMONLY_A_HI = 14'h01BF;
  localparam logic [ADDR_W-1:0] RAMONLY_B_LO = 14'h0280;
  localparam logic [ADDR_W-1:0] RAMONLY_B_HI = 14'h0EFF;
  localparam logic [ADDR_W-1:0] RAMONLY_C_LO = 14'h1000;
  localparam logic [ADDR_W-1:0] RAMONLY_C_HI = 14'h1FFF;

  localparam logic [DATA_W-1:0] CLEAR_VALUE = 16'h0000;

  typedef enum logic [2:0] {
    SNV_RESTORE = 3'b001,
    SNV_CLEAR = 3'b010,
    SNV_IDLE = 3'b100
  } snv_state_t;

  function automatic logic snv_is_shadow(input logic [ADDR_W-1:0] a);
    return (a >= SHADOW_A_LO && a <= SHADOW_A_HI) ||
           (a >= SHADOW_B_LO && a <= SHADOW_B_HI) ||
           (a >= SHADOW_C_LO && a <= SHADOW_C_HI);
  endfunction : snv_is_shadow

  function automatic logic snv_is_ram_only(input logic [ADDR_W-1:0] a);
    return (a >= RAMONLY_A_LO && a <= RAMONLY_A_HI) ||
           (a >= RAMONLY_B_LO && a <= RAMONLY_B_HI) ||
           (a >= RAMONLY_C_LO && a <= RAMONLY_C_HI);
  endfunction : snv_is_ram_only

  function automatic logic snv_is_kept(input logic [ADDR_W-1:0] a,
                                       input logic [ADDR_W-1:0] lo,
                                       input logic [ADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : snv_is_kept

endpackage : snv_pkg

// File: design/snv_nv_store.sv
`timescale 1ns/1ps
module snv_nv_store #(
  parameter int AW = snv_pkg::ADDR_W,
  parameter int DW = snv_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  // Contents survive reset, which stands for the power cycle
  logic [DW-1:0] nv_mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      nv_mem[waddr] <= wdata;
    end
    rdata <= nv_mem[raddr];
  end

endmodule : snv_nv_store

// File: design/snv_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Words inside the retentive range keep values over program-to-run; over power cycle only unshadowed ones keep them, shadowed ones take the nonvolatile copy.
// R2: Words outside the retentive range are cleared after power cycle or program-to-run; the restore pass loads shadowed words from the nonvolatile store instead.
// R3: Listed RAM-only ranges never reach the nonvolatile store.
// R4: Listed shadowed ranges have a nonvolatile copy at the same addresses.
// R5: Move-word writes to shadowed words update nonvolatile store and RAM together.
// R6: Other writes to shadowed words update RAM only.
// R7: Reads always return the RAM copy.
// R8: After power-up the nonvolatile contents are copied into the matching RAM words.
// R9: Requester should limit nonvolatile writes; endurance is about 100,000 writes.
// R10: Requester should issue one nonvolatile write per event, not every scan.
// R11: Busy holds off all requests until the power-up copy has finished.
module snv_core #(
  parameter int AW = snv_pkg::ADDR_W,
  parameter int DW = snv_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_move,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic run_mode,
  input wire logic [AW-1:0] keep_lo,
  input wire logic [AW-1:0] keep_hi,
  output logic busy,
  output logic rd_valid,
  output logic [DW-1:0] rd_data
);

  localparam logic [AW-1:0] LAST_ADDR = {AW{1'b1}};

  logic [DW-1:0] ram_mem [0:(1<<AW)-1];

  snv_pkg::snv_state_t state_r, state_nxt;
  logic [AW-1:0] scan_r, scan_nxt;
  logic [AW-1:0] scan_d_r, scan_d_nxt;
  logic scan_v_r, scan_v_nxt;
  logic issue_r, issue_nxt;
  logic run_d_r, run_d_nxt;
  logic clr_pend_r, clr_pend_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic [DW-1:0] rd_data_r, rd_data_nxt;

  logic accept;
  logic run_rise;
  logic ram_we;
  logic [AW-1:0] ram_waddr;
  logic [DW-1:0] ram_wdata;
  logic nv_we;
  logic [DW-1:0] nv_rdata;
  logic [DW-1:0] ram_peek;

  assign busy = (state_r != snv_pkg::SNV_IDLE); // see R11
  assign accept = req_valid && !busy; // see R11
  assign run_rise = run_mode && !run_d_r;
  assign ram_peek = ram_mem[req_addr];
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;

  // Nonvolatile copy only for move-word writes to shadowed words
  assign nv_we = accept && req_write && req_move && snv_pkg::snv_is_shadow(req_addr); // see R5 R6

  snv_nv_store #(
    .AW(AW),
    .DW(DW)
  ) u_nv ( // see R4
    .clk(clk),
    .we(nv_we), // see R3
    .waddr(req_addr),
    .wdata(req_wdata),
    .raddr(scan_r),
    .rdata(nv_rdata)
  );

  // Pass sequencing: restore after reset, clear after program-to-run
  always_comb begin
    state_nxt = state_r;
    scan_nxt = scan_r + 1'b1;
    scan_d_nxt = scan_r;
    scan_v_nxt = issue_r;
    issue_nxt = issue_r && (scan_r != LAST_ADDR);
    run_d_nxt = run_mode;
    clr_pend_nxt = clr_pend_r || run_rise;
    unique case (state_r)
      snv_pkg::SNV_RESTORE, snv_pkg::SNV_CLEAR: begin
        if (scan_v_r && scan_d_r == LAST_ADDR) begin
          state_nxt = snv_pkg::SNV_IDLE;
        end
      end
      snv_pkg::SNV_IDLE: begin
        scan_nxt = '0;
        scan_v_nxt = 1'b0;
        issue_nxt = 1'b0;
        if (clr_pend_r || run_rise) begin
          state_nxt = snv_pkg::SNV_CLEAR; // see R1 R2
          clr_pend_nxt = 1'b0;
          issue_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = snv_pkg::SNV_RESTORE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= snv_pkg::SNV_RESTORE;
      scan_r <= '0;
      scan_d_r <= '0;
      scan_v_r <= 1'b0;
      issue_r <= 1'b1;
      run_d_r <= 1'b0;
      clr_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      scan_r <= scan_nxt;
      scan_d_r <= scan_d_nxt;
      scan_v_r <= scan_v_nxt;
      issue_r <= issue_nxt;
      run_d_r <= run_d_nxt;
      clr_pend_r <= clr_pend_nxt;
    end
  end

  // RAM write selection: pass writes, else requester writes
  always_comb begin
    ram_we = 1'b0;
    ram_waddr = scan_d_r;
    ram_wdata = snv_pkg::CLEAR_VALUE;
    if (busy) begin
      if (scan_v_r) begin
        if (state_r == snv_pkg::SNV_RESTORE && snv_pkg::snv_is_shadow(scan_d_r)) begin
          ram_we = 1'b1; // see R8
          ram_wdata = nv_rdata;
        end else if (!snv_pkg::snv_is_kept(scan_d_r, keep_lo, keep_hi)) begin
          ram_we = 1'b1; // see R2
        end
      end
    end else if (accept && req_write) begin
      ram_we = 1'b1; // see R5 R6
      ram_waddr = req_addr;
      ram_wdata = req_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_mem[ram_waddr] <= ram_wdata;
    end
  end

  // Reads are served from RAM only
  always_comb begin
    rd_valid_nxt = accept && !req_write;
    rd_data_nxt = rd_data_r;
    if (accept && !req_write) begin
      rd_data_nxt = ram_peek; // see R7
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_busy_after_reset: assert property ($fell(rst) |-> busy && state_r == snv_pkg::SNV_RESTORE) // see R11
    else $error("not busy restoring after reset");
  chk_busy_blocks_req: assert property (busy && req_valid |=> !rd_valid && !$past(nv_we)) // see R11
    else $error("request served while busy");
  chk_move_nv_write: assert property (
    accept && req_write && req_move && snv_pkg::snv_is_shadow(req_addr)
    |-> nv_we && ram_we && ram_wdata == req_wdata) // see R5 R4
    else $error("move write missed a copy");
  chk_other_ram_only: assert property (accept && req_write && !req_move |-> !nv_we && ram_we) // see R6
    else $error("plain write touched nonvolatile store");
  chk_ramonly_no_nv: assert property (nv_we |-> !snv_pkg::snv_is_ram_only(req_addr)) // see R3
    else $error("nonvolatile write to RAM-only word");
  chk_read_from_ram: assert property (accept && !req_write |=> rd_valid && rd_data == $past(ram_peek)) // see R7
    else $error("read data not from RAM");
  chk_restore_copy: assert property (
    state_r == snv_pkg::SNV_RESTORE && scan_v_r && snv_pkg::snv_is_shadow(scan_d_r)
    |-> ram_we && ram_waddr == scan_d_r && ram_wdata == nv_rdata) // see R8
    else $error("restore did not copy nonvolatile word");
  chk_clear_nonkept: assert property (
    busy && scan_v_r && !snv_pkg::snv_is_kept(scan_d_r, keep_lo, keep_hi)
    && !(state_r == snv_pkg::SNV_RESTORE && snv_pkg::snv_is_shadow(scan_d_r))
    |-> ram_we && ram_wdata == snv_pkg::CLEAR_VALUE) // see R2
    else $error("non-retentive word not cleared");
  chk_keep_retentive: assert property (
    state_r == snv_pkg::SNV_CLEAR && scan_v_r && snv_pkg::snv_is_kept(scan_d_r, keep_lo, keep_hi)
    |-> !ram_we) // see R1
    else $error("retentive word overwritten");
  chk_run_starts_clear: assert property (!busy && run_rise |=> state_r == snv_pkg::SNV_CLEAR) // see R2
    else $error("program-to-run did not start clear pass");

  cov_restore_done: cover property (state_r == snv_pkg::SNV_RESTORE ##1 state_r == snv_pkg::SNV_IDLE);
  cov_move_write: cover property (nv_we);
  cov_read: cover property (accept && !req_write);
  cov_clear_pass: cover property (state_r == snv_pkg::SNV_CLEAR ##1 state_r == snv_pkg::SNV_IDLE);

endmodule : snv_core

// File: tb/snv_req_model.sv
`timescale 1ns/1ps
module snv_req_model (
  input wire logic clk,
  input wire logic busy,
  input wire logic go,
  input wire logic wr,
  input wire logic mv,
  input wire logic [13:0] addr,
  input wire logic [15:0] wdata,
  output logic req_valid,
  output logic req_write,
  output logic req_move,
  output logic [13:0] req_addr,
  output logic [15:0] req_wdata
);
  logic go_r;
  initial begin
    go_r = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_move = 1'b0;
    req_addr = 14'h0000;
    req_wdata = 16'h0000;
  end
  // Held until an edge with busy low takes it; released address and data flip so stale values never match
  always @(posedge clk) begin
    go_r <= go;
    if (req_valid && !busy) begin
      req_valid <= 1'b0;
      req_addr <= ~req_addr;
      req_wdata <= ~req_wdata;
    end else if (go && !go_r) begin
      req_valid <= 1'b1;
      req_write <= wr;
      req_move <= mv;
      req_addr <= addr;
      req_wdata <= wdata;
    end
  end
endmodule : snv_req_model

// File: tb/shadowed_nonvolatile_data_memory_tb.sv
`timescale 1ns/1ps
module shadowed_nonvolatile_data_memory_tb;
  typedef struct packed {
    logic [13:0] a;
    logic mv;
    logic [15:0] d;
    logic [15:0] ep;
    logic [15:0] er;
  } snv_row_t;
  // Address, move path, data, value after power cycle, value after run step
  snv_row_t tbl [9] = '{
    '{14'h01C0, 1'b1, 16'h1111, 16'h1111, 16'h0000},
    '{14'h01C0, 1'b0, 16'h2222, 16'h1111, 16'h0000},
    '{14'h0F7F, 1'b1, 16'h3333, 16'h3333, 16'h0000},
    '{14'h3C00, 1'b1, 16'h4444, 16'h4444, 16'h0000},
    '{14'h0100, 1'b1, 16'h7777, 16'h7777, 16'h7777},
    '{14'h0110, 1'b0, 16'h5555, 16'h5555, 16'h5555},
    '{14'h0111, 1'b0, 16'h6666, 16'h0000, 16'h0000},
    '{14'h1000, 1'b1, 16'h8888, 16'h0000, 16'h0000},
    '{14'h0EFF, 1'b0, 16'h9999, 16'h0000, 16'h0000}};
  logic clk, rst, go, wr, mv, run_mode, busy, rd_valid;
  logic req_valid, req_write, req_move;
  logic [13:0] addr, keep_lo, keep_hi, req_addr;
  logic [15:0] wdata, req_wdata, rd_data;
  int err_count = 0;
  int cmp_count = 0;

  snv_req_model req_u (.clk(clk), .busy(busy), .go(go), .wr(wr), .mv(mv), .addr(addr),
    .wdata(wdata), .req_valid(req_valid), .req_write(req_write), .req_move(req_move),
    .req_addr(req_addr), .req_wdata(req_wdata));
  snv_core dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_move(req_move), .req_addr(req_addr), .req_wdata(req_wdata), .run_mode(run_mode),
    .keep_lo(keep_lo), .keep_hi(keep_hi), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data));

  always #2.5 clk = ~clk;

  task automatic chk_word(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %b got %b", nm, exp, got);
    end
  endtask : chk_bit

  // Hands one request to the model and waits until an edge has taken it
  task automatic op(input logic w, input logic m, input logic [13:0] a, input logic [15:0] d);
    int n;
    n = 0;
    wr = w;
    mv = m;
    addr = a;
    wdata = d;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    @(negedge clk);
    while (req_valid !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
  endtask : op

  task automatic rd(input logic [13:0] a, input logic [15:0] exp);
    op(1'b0, 1'b0, a, 16'h0000);
    chk_bit("rd_valid", 1'b1, rd_valid);
    chk_word("rd_data", exp, rd_data);
    @(negedge clk);
    chk_bit("rd_valid_pulse", 1'b0, rd_valid);
  endtask : rd

  task automatic settle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk_bit("pass_done", 1'b0, busy);
    chk_word("pass_cycles", 16'((1 << snv_pkg::ADDR_W) + 1), n[15:0]);
  endtask : settle

  task automatic power();
    run_mode = 1'b0;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    chk_bit("busy_in_rst", 1'b1, busy);
    chk_bit("rd_valid_in_rst", 1'b0, rd_valid);
    rst = 1'b0;
    settle();
  endtask : power

  task automatic close_out();
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    go = 1'b0;
    wr = 1'b0;
    mv = 1'b0;
    addr = 14'h0000;
    wdata = 16'h0000;
    keep_lo = 14'h0100;
    keep_hi = 14'h0110;
    power();
    foreach (tbl[i]) begin
      op(1'b1, tbl[i].mv, tbl[i].a, tbl[i].d);
      rd(tbl[i].a, tbl[i].d);
    end
    power();
    foreach (tbl[i]) rd(tbl[i].a, tbl[i].ep);
    run_mode = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit("busy_after_run", 1'b1, busy);
    rd(14'h0100, 16'h7777);
    foreach (tbl[i]) rd(tbl[i].a, tbl[i].er);
    power();
    rd(14'h01C0, 16'h1111);
    rd(14'h0100, 16'h7777);
    close_out();
  end

  initial begin
    #(5 * 80000);
    err_count++;
    close_out();
  end
endmodule : shadowed_nonvolatile_data_memory_tb
